// *** icc_top.v ***
// eight-channel capture/compare group with apb registers
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "icc_consts.vh"
module icc_top #(
  parameter NCH = 8,
  parameter TW = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [TW-1:0] base_timer,
  input wire [7:0] trigger_in_pin_a,
  input wire [7:0] trigger_in_pin_b,
  output reg [7:0] wave_out_pin,
  output reg irq
);
  reg [7:0] function_select_reg_q;
  reg [7:0] function_enable_reg_q;
  reg input_route_sel_q;
  reg [7:0] irq_stat_q;
  reg [7:0] irq_mask_q;
  reg [7:0] prescale_value_reg_q [6:7];
  reg [7:0] pre_cnt_q [6:7];
  reg [7:0] capture_ctrl_reg_q [0:7];
  reg [7:0] compare_ctrl_reg_q [0:7];
  reg [TW-1:0] compare_buf_q [0:7];
  reg [TW-1:0] compare_value_reg_q [0:7];
  reg [TW-1:0] capture_value_reg_q [0:7];
  reg [7:0] sync1_a_q;
  reg [7:0] sync2_a_q;
  reg [7:0] sync1_b_q;
  reg [7:0] sync2_b_q;
  reg [7:0] filt_prev_q;
  reg [7:0] gate_closed_q;
  reg [7:0] wave_q;
  reg [7:0] en_prev_q;
  wire [7:0] filt;
  wire [7:0] trig_routed;
  wire acc = psel && penable && !pready;
  wire wr = acc && pwrite;
  wire [2:0] idx = paddr[4:2];
  reg [7:0] cap_ev;
  reg [7:0] match;
  reg [7:0] wclr;
  integer i;
  integer ci;
  integer oi;
  integer bi;

  function [7:0] field;
    input [7:0] r;
    input integer lo;
    begin
      field = (r >> lo) & 8'h03;
    end
  endfunction

  // both groups synchronised, route pick happens after both stages
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_a_q <= 8'h00;
      sync2_a_q <= 8'h00;
      sync1_b_q <= 8'h00;
      sync2_b_q <= 8'h00;
    end else begin
      sync1_a_q <= trigger_in_pin_a;
      sync2_a_q <= sync1_a_q;
      sync1_b_q <= trigger_in_pin_b;
      sync2_b_q <= sync1_b_q;
    end
  end

  // one route select picks the pin group for all channels
  // a route switch can pass one stray edge; let it settle first
  assign trig_routed = input_route_sel_q ? sync2_b_q : sync2_a_q;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gf
      icc_filter #(.N(`ICC_FILT_COUNT)) u_f (
        .pclk(pclk),
        .presetn(presetn),
        .en(field(capture_ctrl_reg_q[g], `ICC_CC_FILT_LO) != {6'h0, `ICC_FILT_OFF}),
        .din(trig_routed[g]),
        .dout(filt[g])
      );
    end
  endgenerate

  // edge detect and match per channel
  always @* begin
    for (ci = 0; ci < 8; ci = ci + 1) begin
      match[ci] = 1'b0;
      cap_ev[ci] = 1'b0;
      if (function_enable_reg_q[ci]) begin
        match[ci] = base_timer == compare_value_reg_q[ci];
        case (field(capture_ctrl_reg_q[ci], `ICC_CC_TRIG_LO))
          {6'h0, `ICC_TRIG_RISE}: cap_ev[ci] = filt[ci] && !filt_prev_q[ci];
          {6'h0, `ICC_TRIG_FALL}: cap_ev[ci] = !filt[ci] && filt_prev_q[ci];
          {6'h0, `ICC_TRIG_BOTH}: cap_ev[ci] = filt[ci] != filt_prev_q[ci];
          default: cap_ev[ci] = 1'b0;
        endcase
        cap_ev[ci] = cap_ev[ci] && function_select_reg_q[ci];
        // gate blocks trigger after a capture
        if (capture_ctrl_reg_q[ci][`ICC_CC_GATE_EN] && gate_closed_q[ci]) begin
          cap_ev[ci] = 1'b0;
        end
      end
    end
  end

  always @* begin
    wclr = 8'h00;
    if (wr && paddr == `ICC_OFF_IRQ_STAT) begin
      wclr = pwdata[7:0];
    end
  end

  // capture, prescale, gate, waveform state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_prev_q <= 8'h00;
      gate_closed_q <= 8'h00;
      wave_q <= 8'h00;
      en_prev_q <= 8'h00;
      irq_stat_q <= 8'h00;
      pre_cnt_q[6] <= 8'h00;
      pre_cnt_q[7] <= 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        capture_value_reg_q[i] <= {TW{1'b0}};
        compare_value_reg_q[i] <= {TW{1'b0}};
      end
    end else begin
      filt_prev_q <= filt;
      en_prev_q <= function_enable_reg_q;
      irq_stat_q <= (irq_stat_q & ~wclr) | (match & ~function_select_reg_q);
      for (i = 0; i < 8; i = i + 1) begin
        if (cap_ev[i]) begin
          if (i >= 6 && capture_ctrl_reg_q[i][`ICC_CC_PRE_EN] &&
              pre_cnt_q[i] != prescale_value_reg_q[i]) begin
            pre_cnt_q[i] <= pre_cnt_q[i] + 8'h01;
          end else begin
            if (i >= 6) begin
              pre_cnt_q[i] <= 8'h00;
            end
            capture_value_reg_q[i] <= base_timer;
            irq_stat_q[i] <= 1'b1;
            gate_closed_q[i] <= 1'b1;
          end
        end
        // gate reopen by match or soft clear
        if ((capture_ctrl_reg_q[i][`ICC_CC_GATE_MATCH] && match[i]) ||
            (wr && paddr == `ICC_OFF_CAP_CTRL + {7'h0, i[2:0], 2'h0} &&
             pwdata[`ICC_CC_GATE_SOFT])) begin
          gate_closed_q[i] <= 1'b0;
        end
        if (!compare_ctrl_reg_q[i][`ICC_PC_RELOAD] || base_timer == {TW{1'b0}}) begin
          compare_value_reg_q[i] <= compare_buf_q[i];
        end
        if (function_enable_reg_q[i] && !en_prev_q[i]) begin
          wave_q[i] <= compare_ctrl_reg_q[i][`ICC_PC_START_LVL];
        end else if (function_enable_reg_q[i] && !function_select_reg_q[i]) begin
          case (compare_ctrl_reg_q[i][2:0])
            `ICC_MODE_SINGLE: begin
              // high on match, low at zero
              if (match[i]) begin
                wave_q[i] <= 1'b1;
              end else if (base_timer == {TW{1'b0}}) begin
                wave_q[i] <= 1'b0;
              end
            end
            `ICC_MODE_DELAY: begin
              if (match[i]) begin
                wave_q[i] <= !wave_q[i];
              end
            end
            `ICC_MODE_SR: begin
              // set on own match, reset at timer zero
              if (match[i]) begin
                wave_q[i] <= 1'b1;
              end else if (base_timer == {TW{1'b0}}) begin
                wave_q[i] <= 1'b0;
              end
            end
            default: wave_q[i] <= wave_q[i];
          endcase
        end
      end
    end
  end

  // invert on the way to the pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_out_pin <= 8'h00;
      irq <= 1'b0;
    end else begin
      for (oi = 0; oi < 8; oi = oi + 1) begin
        wave_out_pin[oi] <= function_enable_reg_q[oi] && !function_select_reg_q[oi] &&
          (wave_q[oi] ^ compare_ctrl_reg_q[oi][`ICC_PC_INVERT]);
      end
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // apb slave, one wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      function_select_reg_q <= 8'h00;
      function_enable_reg_q <= 8'h00;
      input_route_sel_q <= 1'b0;
      irq_mask_q <= 8'h00;
      prescale_value_reg_q[6] <= 8'h00;
      prescale_value_reg_q[7] <= 8'h00;
      for (bi = 0; bi < 8; bi = bi + 1) begin
        capture_ctrl_reg_q[bi] <= 8'h00;
        compare_ctrl_reg_q[bi] <= 8'h00;
        compare_buf_q[bi] <= {TW{1'b0}};
      end
    end else begin
      pready <= acc;
      pslverr <= 1'b0;
      if (acc && paddr[1:0] != 2'h0) begin
        // no byte lanes: refuse rather than alias a whole word
        pslverr <= 1'b1;
        prdata <= 32'h00000000;
      end else if (acc) begin
        prdata <= 32'h00000000;
        case (paddr & 12'hfe0)
          12'h000: begin
            case (paddr)
              `ICC_OFF_FSEL: prdata[7:0] <= function_select_reg_q;
              `ICC_OFF_FEN: prdata[7:0] <= function_enable_reg_q;
              `ICC_OFF_ROUTE: prdata[0] <= input_route_sel_q;
              `ICC_OFF_IRQ_STAT: prdata[7:0] <= irq_stat_q;
              `ICC_OFF_IRQ_MASK: prdata[7:0] <= irq_mask_q;
              `ICC_OFF_TIMER: prdata[TW-1:0] <= base_timer;
              `ICC_OFF_PRE6: prdata[7:0] <= prescale_value_reg_q[6];
              `ICC_OFF_PRE7: prdata[7:0] <= prescale_value_reg_q[7];
              default: pslverr <= 1'b1;
            endcase
            if (wr) begin
              case (paddr)
                `ICC_OFF_FSEL: function_select_reg_q <= pwdata[7:0];
                `ICC_OFF_FEN: function_enable_reg_q <= pwdata[7:0];
                `ICC_OFF_ROUTE: input_route_sel_q <= pwdata[0];
                `ICC_OFF_IRQ_MASK: irq_mask_q <= pwdata[7:0];
                `ICC_OFF_PRE6: prescale_value_reg_q[6] <= pwdata[7:0];
                `ICC_OFF_PRE7: prescale_value_reg_q[7] <= pwdata[7:0];
                default: ;
              endcase
            end
          end
          `ICC_OFF_CAP_CTRL: begin
            prdata[7:0] <= capture_ctrl_reg_q[idx];
            if (wr) begin
              // soft clear bit is a strobe, not stored
              capture_ctrl_reg_q[idx] <= pwdata[7:0] & ~(8'h01 << `ICC_CC_GATE_SOFT);
            end
          end
          `ICC_OFF_CMP_CTRL: begin
            prdata[7:0] <= compare_ctrl_reg_q[idx];
            if (wr) begin
              compare_ctrl_reg_q[idx] <= pwdata[7:0];
            end
          end
          `ICC_OFF_CMP_VAL: begin
            prdata[TW-1:0] <= compare_buf_q[idx];
            if (wr) begin
              compare_buf_q[idx] <= pwdata[TW-1:0];
            end
          end
          `ICC_OFF_CAP_VAL: prdata[TW-1:0] <= capture_value_reg_q[idx];
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** icc_consts.vh ***
// constants for the eight-channel capture/compare group
`ifndef ICC_CONSTS_VH
`define ICC_CONSTS_VH
`define ICC_OFF_FSEL 12'h000
`define ICC_OFF_FEN 12'h004
`define ICC_OFF_ROUTE 12'h008
`define ICC_OFF_IRQ_STAT 12'h00c
`define ICC_OFF_IRQ_MASK 12'h010
`define ICC_OFF_TIMER 12'h014
`define ICC_OFF_PRE6 12'h018
`define ICC_OFF_PRE7 12'h01c
`define ICC_OFF_CAP_CTRL 12'h100
`define ICC_OFF_CMP_CTRL 12'h140
`define ICC_OFF_CMP_VAL 12'h180
`define ICC_OFF_CAP_VAL 12'h1c0
`define ICC_CC_TRIG_LO 0
`define ICC_CC_FILT_LO 2
`define ICC_CC_GATE_EN 4
`define ICC_CC_GATE_MATCH 5
`define ICC_CC_GATE_SOFT 6
`define ICC_CC_PRE_EN 7
`define ICC_PC_MODE_LO 0
`define ICC_PC_START_LVL 4
`define ICC_PC_RELOAD 5
`define ICC_PC_INVERT 6
`define ICC_MODE_SINGLE 3'h0
`define ICC_MODE_DELAY 3'h1
`define ICC_MODE_SR 3'h2
`define ICC_TRIG_RISE 2'h0
`define ICC_TRIG_FALL 2'h1
`define ICC_TRIG_BOTH 2'h2
`define ICC_FILT_OFF 2'h0
`define ICC_FILT_COUNT 3
`endif

// *** icc_filter.v ***
// trigger noise filter: passes a level after four equal samples in a row
`timescale 1ns/1ns
`default_nettype none
module icc_filter #(
  parameter N = 3
) (
  input wire pclk,
  input wire presetn,
  input wire en,
  input wire din,
  output reg dout
);
  reg [1:0] cnt_q;
  reg last_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
      last_q <= 1'b0;
      dout <= 1'b0;
    end else if (!en) begin
      last_q <= din;
      cnt_q <= 2'h0;
      dout <= din;
    end else begin
      last_q <= din;
      if (din != last_q) begin
        cnt_q <= 2'h0;
      end else if (cnt_q != N[1:0] - 2'h1) begin
        cnt_q <= cnt_q + 2'h1;
      end else begin
        dout <= din;
      end
    end
  end
endmodule
`default_nettype wire

// *** icc_top_asserts.sv ***
// checker of bus handshake and output timing at the group's ports
`timescale 1ns/1ns
`default_nettype none
module icc_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] wave_out_pin,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic hit;
  // word-aligned offsets of the four channel banks and the common registers
  assign hit = paddr[11:9] == 3'h0 && paddr[1:0] == 2'h0 && !paddr[5] &&
    (paddr[8] || paddr[7:6] == 2'h0);
  property p_rdy; psel && penable && !pready |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing after one wait");
  property p_wait; $rose(penable) |-> !pready; endproperty
  a_wait: assert property (p_wait) else $error("ready without a wait state");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_err; pslverr |-> pready && !hit; endproperty
  a_err: assert property (p_err) else $error("error on a mapped address");
  property p_unm; pready && !hit |-> pslverr; endproperty
  a_unm: assert property (p_unm) else $error("unmapped address accepted");
  property p_rst; $rose(presetn) |-> wave_out_pin == 8'h00 && !irq; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_irq; pready && pwrite && paddr == 12'h010 && pwdata == 32'h0 |-> ##2 !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt while fully masked");
  property p_off; pready && pwrite && paddr == 12'h004 && pwdata == 32'h0
    |-> ##3 wave_out_pin == 8'h00; endproperty
  a_off: assert property (p_off) else $error("output active while disabled");
endmodule
bind icc_top icc_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .wave_out_pin(wave_out_pin), .irq(irq));
`default_nettype wire

// *** icc_pins.sv ***
// trigger pin groups: the routed group follows the bench, the other is noise
`timescale 1ns/1ns
`default_nettype none
module icc_pins (
  input wire logic pclk,
  input wire logic route,
  input wire logic [7:0] lvl,
  output logic [7:0] pin_a,
  output logic [7:0] pin_b
);
  logic [7:0] noise = 8'h00;
  always @(posedge pclk) noise <= 8'($urandom);
  assign pin_a = route ? noise : lvl;
  assign pin_b = route ? lvl : noise;
endmodule
`default_nettype wire

// *** icc_top_tb.sv ***
// self-checking bench for the capture/compare group
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module icc_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, route = 0, x;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, irq;
  logic [15:0] base_timer = 0;
  logic [7:0] lvl = 0, pin_a, pin_b, wave_out_pin;
  int bad_count = 0, n_compared = 0, c;
  icc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .base_timer(base_timer), .trigger_in_pin_a(pin_a),
    .trigger_in_pin_b(pin_b), .wave_out_pin(wave_out_pin), .irq(irq));
  icc_pins u_pins (.pclk(pclk), .route(route), .lvl(lvl), .pin_a(pin_a), .pin_b(pin_b));
  always #10 pclk = ~pclk;
  // timer runs first
  // short 64-count period keeps every waveform cycle brief
  always @(posedge pclk) base_timer <= presetn ? (base_timer + 16'h1) & 16'h3f : 16'h0;
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic wait_t(input int t);
    repeat (70) if (base_timer != t) @(posedge pclk);
  endtask
  function automatic logic exp_lvl(input int t, input logic output_invert);
    return (t >= c) ^ output_invert;
  endfunction
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    print_verdict;
  end
  initial begin
    void'($urandom(47269));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(12'h000, 32'h0);
    rchk(12'h004, 32'h0);
    rchk(12'h0f0, 32'h0);
    c = 10 + $urandom % 40;
    for (int j = 0; j < 8; j++) apb(1'b1, 12'h180 + 12'(4 * j), 32'(c));
    rchk(12'h19c, 32'(c));
    $display("register test done");
    apb(1'b1, 12'h140, 32'h0);
    apb(1'b1, 12'h144, 32'h40);
    apb(1'b1, 12'h14c, 32'h1);
    apb(1'b1, 12'h150, 32'h2);
    apb(1'b1, 12'h154, 32'h10);
    apb(1'b1, 12'h158, 32'h20);
    apb(1'b1, 12'h010, 32'h1);
    // enable lands near timer 5, before the earliest match at 10
    wait_t(2);
    apb(1'b1, 12'h004, 32'h7b);
    wait_t(9);
    `CHK(wave_out_pin[5], 1'b1)
    `CHK(wave_out_pin[0], 1'b0)
    repeat (64) @(posedge pclk);
    repeat (64) begin
      @(posedge pclk);
      if (base_timer > 3 && (base_timer < c || base_timer > c + 3)) begin
        `CHK(wave_out_pin[0], exp_lvl(base_timer, 1'b0))
        `CHK(wave_out_pin[1], exp_lvl(base_timer, 1'b1))
        `CHK(wave_out_pin[4], exp_lvl(base_timer, 1'b0))
        `CHK(wave_out_pin[5], exp_lvl(base_timer, 1'b0))
      end
    end
    `CHK(irq, 1'b1)
    wait_t(c + 8);
    x = wave_out_pin[3];
    wait_t(c + 7);
    wait_t(c + 8);
    `CHK(wave_out_pin[3], ~x)
    // channel 6 reloads at timer zero: old value rules this period
    wait_t(1);
    apb(1'b1, 12'h198, 32'(c + 8));
    wait_t(c + 4);
    `CHK(wave_out_pin[6], 1'b1)
    wait_t(c + 3);
    wait_t(c + 4);
    `CHK(wave_out_pin[6], 1'b0)
    wait_t(c + 12);
    `CHK(wave_out_pin[6], 1'b1)
    apb(1'b1, 12'h004, 32'h0);
    repeat (4) @(posedge pclk);
    `CHK(wave_out_pin, 8'h00)
    apb(1'b1, 12'h00c, 32'hff);
    rchk(12'h00c, 32'h0);
    `CHK(irq, 1'b0)
    $display("compare test done");
    apb(1'b1, 12'h000, 32'h4);
    apb(1'b1, 12'h010, 32'h4);
    apb(1'b1, 12'h004, 32'h4);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, 12'h008, 32'(m % 2));
      route <= m[0];
      apb(1'b1, 12'h108, 32'(m == 2 ? 6 : m));
      // route switch may leave a stray edge in the pipeline
      repeat (8) @(posedge pclk);
      apb(1'b1, 12'h00c, 32'hff);
      wait_t(8);
      lvl[2] <= 1'b1;
      repeat (12) @(posedge pclk);
      `CHK(irq, m != 1)
      apb(1'b0, 12'h1c8, 32'h0);
      `CHK((rd >= 8 && rd <= 20) || m == 1, 1'b1)
      apb(1'b1, 12'h00c, 32'hff);
      wait_t(40);
      lvl[2] <= 1'b0;
      repeat (12) @(posedge pclk);
      `CHK(irq, m != 0)
    end
    // channel 6: capture every second rise, gate shut until soft clear
    apb(1'b1, 12'h018, 32'h1);
    rchk(12'h018, 32'h1);
    apb(1'b1, 12'h118, 32'h90);
    apb(1'b1, 12'h000, 32'h40);
    apb(1'b1, 12'h010, 32'h40);
    apb(1'b1, 12'h004, 32'h40);
    apb(1'b1, 12'h00c, 32'hff);
    for (int p = 0; p < 5; p++) begin
      lvl[6] <= 1'b1;
      repeat (8) @(posedge pclk);
      `CHK(irq, p == 1 || p == 4)
      lvl[6] <= 1'b0;
      repeat (8) @(posedge pclk);
      apb(1'b1, 12'h00c, 32'hff);
      if (p == 2) apb(1'b1, 12'h118, 32'hd0);
    end
    apb(1'b1, 12'h010, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b0)
    $display("capture test done");
    print_verdict;
  end
endmodule
`default_nettype wire
